// >>> shared/spc_params.svh
// Offsets, field positions, reset values for the serial port control block.
// Assumes inclusion by the design file only.
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
// =====================================================
// Register indices (byte address is four times index)
`define SPC_IDX_PWR   10'h087
`define SPC_IDX_S1CTL 10'h0F8
`define SPC_IDX_T3CTL 10'h0C4
`define SPC_IDX_S0CTL 10'h098
`define SPC_IDX_ISTAT 10'h100
`define SPC_IDX_IEN   10'h101
`define SPC_IDX_ICLR  10'h102
`define SPC_IDX_BITOP 10'h103
// =====================================================
// Field positions
`define SPC_B_MODE_HI 7
`define SPC_B_MODE_LO 6
`define SPC_B_MP      5
`define SPC_B_REN     4
`define SPC_B_TB8     3
`define SPC_B_RB8     2
`define SPC_B_TI      1
`define SPC_B_RI      0
`define SPC_B_BAUD2   7
`define SPC_B_FESEL   6
`define SPC_B_BITWR   8
`define SPC_B_BITVAL  4
// =====================================================
// Reset values
`define SPC_RST_PWR   8'h10
`define SPC_RST_S1    8'h00
`define SPC_RST_T3    8'h00
`define SPC_RST_S0    8'h00
`define SPC_RST_IRQ   3'h0
`endif

// >>> shared/spc_pkg.sv
// Types shared by the serial port control block.
// Assumes the params header sits beside it on the include path.
`default_nettype none
package spc_pkg;
  // Bus address and data views
  typedef logic [11:0] spc_addr_t;
  typedef logic [7:0]  spc_byte_t;
  typedef logic [1:0]  spc_mode_t;
  // AXI answer codes in use
  typedef enum logic [1:0] {
    SPC_RESP_OKAY   = 2'h0,
    SPC_RESP_SLVERR = 2'h2
  } spc_resp_t;
endpackage
`default_nettype wire

// >>> verilog/spc_serial_port_control.sv
// Control and status registers of serial port 1 and port-0 serial bits.
// Assumes shift engines on the same clock give one-cycle event pulses,
// and an AXI4-Lite master on the same clock reaches the registers.
//
// Functional notes
// R01 - Port1 bits 7:6 are mode when select 0
// R02 - Select 1: bit 7 is frame error flag
// R03 - Mode 0 ignores multiprocessor enable
// R04 - Mode 1 checks stop bit and address
// R05 - Modes 2/3 check ninth bit and address
// R06 - Receive enable gates reception; mode 0 needs RI=0
// R07 - Ninth transmit bit only in modes 2/3
// R08 - Ninth receive bit captures ninth or stop
// R09 - Transmit flag set at frame end
// R10 - Receive flag set unless frame rejected
// R11 - Only software clears the two flags
// R12 - Enabled flags raise the interrupt request
// R13 - Baud doubler acts in port0 modes 1-3 (modes 1 and 3 only with timer 1 as baud source)
// R14 - Port0 select routes bit 7 likewise
// R15 - Port1 control bits singly accessible too
// R16 - Port1 select lives in timer3 bit 6
// R17 - Stop bit 0 sets frame error in modes 1-3
`include "spc_params.svh"
`default_nettype none
module spc_serial_port_control (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire spc_pkg::spc_addr_t  i_s_axi_awaddr,
  input  wire logic                i_s_axi_awvalid,
  output logic                     o_s_axi_awready,
  input  wire logic [31:0]         i_s_axi_wdata,
  input  wire logic [3:0]          i_s_axi_wstrb,
  input  wire logic                i_s_axi_wvalid,
  output logic                     o_s_axi_wready,
  output spc_pkg::spc_resp_t       o_s_axi_bresp,
  output logic                     o_s_axi_bvalid,
  input  wire logic                i_s_axi_bready,
  input  wire spc_pkg::spc_addr_t  i_s_axi_araddr,
  input  wire logic                i_s_axi_arvalid,
  output logic                     o_s_axi_arready,
  output logic [31:0]              o_s_axi_rdata,
  output spc_pkg::spc_resp_t       o_s_axi_rresp,
  output logic                     o_s_axi_rvalid,
  input  wire logic                i_s_axi_rready,
  input  wire logic                i_p1_tx_done,
  input  wire logic                i_p1_rx_done,
  input  wire logic                i_p1_rx_stop,
  input  wire logic                i_p1_rx_ninth,
  input  wire logic                i_p1_rx_addr_match,
  input  wire logic                i_p0_rx_frame_error,
  input  wire logic                i_p0_t1_baud_src,
  output spc_pkg::spc_mode_t       o_p1_mode,
  output logic                     o_p1_rx_enable,
  output logic                     o_p1_tx_ninth,
  output spc_pkg::spc_mode_t       o_p0_mode,
  output logic                     o_p0_baud_double,
  output logic                     o_irq
);
  import spc_pkg::*;

  // =====================================================
  // Helper functions

  // Byte address of a register index
  function automatic spc_addr_t spc_addr(input logic [9:0] idx);
    spc_addr = {idx, 2'h0};
  endfunction

  // Replace masked bits of a byte
  function automatic spc_byte_t spc_merge(input spc_byte_t old,
                                          input spc_byte_t dat,
                                          input spc_byte_t msk);
    spc_merge = (old & ~msk) | (dat & msk);
  endfunction

  // Multiprocessor validity of a finished reception
  function automatic logic spc_rx_valid(input spc_mode_t mode,
                                        input logic mp,
                                        input logic stop,
                                        input logic ninth,
                                        input logic match);
    if (!mp || mode == 2'h0) begin
      spc_rx_valid = 1'b1;
    end else if (mode == 2'h1) begin
      spc_rx_valid = stop && match;
    end else begin
      spc_rx_valid = ninth && match;
    end
  endfunction

  // =====================================================
  // Register state
  spc_byte_t  pwr;          // Power and port0 serial bits
  spc_byte_t  t3;           // Timer3 control, bit 6 is port1 select
  spc_byte_t  s0;           // Port0 control, bit 7 is mode-high
  spc_byte_t  s1;           // Port1 control, bit 7 is mode-high
  logic       s0_fe;        // Port0 frame error flag
  logic       s1_fe;        // Port1 frame error flag
  logic [2:0] irq_stat;     // Sticky events: fe, rx, tx
  logic [2:0] irq_en;       // Event enables
  logic [2:0] bit_sel;      // Selected port1 bit
  spc_byte_t  next_pwr;
  spc_byte_t  next_t3;
  spc_byte_t  next_s0;
  spc_byte_t  next_s1;
  logic       next_s0_fe;
  logic       next_s1_fe;
  logic [2:0] next_irq_stat;
  logic [2:0] next_irq_en;
  logic [2:0] next_bit_sel;
  spc_mode_t  next_p1_mode;
  logic       next_p1_rx_enable;
  logic       next_p1_tx_ninth;
  spc_mode_t  next_p0_mode;
  logic       next_p0_baud_double;
  logic       next_irq;

  // =====================================================
  // Bus state
  logic       aw_held;      // Write address captured
  logic       w_held;       // Write data captured
  spc_addr_t  awaddr_q;     // Captured write address
  logic [31:0] wdata_q;     // Captured write data
  logic       wlane_q;      // Low byte lane enabled
  logic       next_aw_held;
  logic       next_w_held;
  spc_addr_t  next_awaddr;
  logic [31:0] next_wdata;
  logic       next_wlane;
  logic       next_awready;
  logic       next_wready;
  logic       next_bvalid;
  spc_resp_t  next_bresp;
  logic       next_arready;
  logic       next_rvalid;
  logic [31:0] next_rdata;
  spc_resp_t  next_rresp;

  // Decode results
  logic       wr_go;        // Both halves of a write are present
  logic       wr_hit;       // Write address is mapped
  logic [31:0] rd_word;     // Read data for the request address
  logic       rd_hit;       // Read address is mapped
  spc_byte_t  s1_view;      // Port1 control as software sees it
  spc_byte_t  s0_view;      // Port0 control as software sees it

  // Events
  spc_mode_t  p1_mode;
  spc_mode_t  p0_mode;
  logic       rx_take;      // Finished reception that was allowed
  logic       ri_set;
  logic       ti_set;
  logic       fe1_set;
  logic       s1_wr;        // Any software access writing port1 control
  spc_byte_t  s1_mask;
  spc_byte_t  s1_data;

  // Software views of bit 7 follow the access selects
  assign s1_view = {t3[`SPC_B_FESEL] ? s1_fe : s1[`SPC_B_MODE_HI], s1[6:0]}; // [R02] [R16]
  assign s0_view = {pwr[`SPC_B_FESEL] ? s0_fe : s0[`SPC_B_MODE_HI], s0[6:0]}; // [R14]
  assign p1_mode = {s1[`SPC_B_MODE_HI], s1[`SPC_B_MODE_LO]};
  assign p0_mode = {s0[`SPC_B_MODE_HI], s0[`SPC_B_MODE_LO]};

  // =====================================================
  // Read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (i_s_axi_araddr == spc_addr(`SPC_IDX_PWR)) begin
      rd_word = {24'h00_0000, pwr};
    end else if (i_s_axi_araddr == spc_addr(`SPC_IDX_S1CTL)) begin
      rd_word = {24'h00_0000, s1_view};
    end else if (i_s_axi_araddr == spc_addr(`SPC_IDX_T3CTL)) begin
      rd_word = {24'h00_0000, t3};
    end else if (i_s_axi_araddr == spc_addr(`SPC_IDX_S0CTL)) begin
      rd_word = {24'h00_0000, s0_view};
    end else if (i_s_axi_araddr == spc_addr(`SPC_IDX_ISTAT)) begin
      rd_word = {29'h0000_0000, irq_stat};
    end else if (i_s_axi_araddr == spc_addr(`SPC_IDX_IEN)) begin
      rd_word = {29'h0000_0000, irq_en};
    end else if (i_s_axi_araddr == spc_addr(`SPC_IDX_ICLR)) begin
      rd_word = 32'h0000_0000;          // Write-only, reads zero
    end else if (i_s_axi_araddr == spc_addr(`SPC_IDX_BITOP)) begin
      rd_word = {27'h000_0000, s1_view[bit_sel], 1'b0, bit_sel}; // [R15]
    end else begin
      rd_hit = 1'b0;                     // Unmapped
    end
  end

  // Write address hit
  always_comb begin
    if (awaddr_q == spc_addr(`SPC_IDX_PWR)) begin
      wr_hit = 1'b1;
    end else if (awaddr_q == spc_addr(`SPC_IDX_S1CTL)) begin
      wr_hit = 1'b1;
    end else if (awaddr_q == spc_addr(`SPC_IDX_T3CTL)) begin
      wr_hit = 1'b1;
    end else if (awaddr_q == spc_addr(`SPC_IDX_S0CTL)) begin
      wr_hit = 1'b1;
    end else if (awaddr_q[11:4] == 8'(spc_addr(`SPC_IDX_ISTAT) >> 4)) begin
      wr_hit = 1'b1;                     // Interrupt and bit registers
    end else begin
      wr_hit = 1'b0;
    end
  end

  // =====================================================
  // AXI4-Lite handshakes: next values
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_awaddr  = awaddr_q;
    next_wdata   = wdata_q;
    next_wlane   = wlane_q;
    next_bvalid  = o_s_axi_bvalid;
    next_bresp   = o_s_axi_bresp;
    next_rvalid  = o_s_axi_rvalid;
    next_rdata   = o_s_axi_rdata;
    next_rresp   = o_s_axi_rresp;
    wr_go        = aw_held && w_held && !o_s_axi_bvalid;
    // Address and data are taken in either order
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      next_aw_held = 1'b1;
      next_awaddr  = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      next_w_held = 1'b1;
      next_wdata  = i_s_axi_wdata;
      next_wlane  = i_s_axi_wstrb[0];
    end
    // Commit and answer once both are held
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_hit ? SPC_RESP_OKAY : SPC_RESP_SLVERR;
    end else if (o_s_axi_bvalid && i_s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // Read answers one cycle after the address is taken
    if (i_s_axi_arvalid && o_s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = rd_hit ? SPC_RESP_OKAY : SPC_RESP_SLVERR;
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // AXI4-Lite handshakes: registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      awaddr_q        <= 12'h000;
      wdata_q         <= 32'h0000_0000;
      wlane_q         <= 1'b0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready  <= 1'b0;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= SPC_RESP_OKAY;
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h0000_0000;
      o_s_axi_rresp   <= SPC_RESP_OKAY;
    end else begin
      aw_held         <= next_aw_held;
      w_held          <= next_w_held;
      awaddr_q        <= next_awaddr;
      wdata_q         <= next_wdata;
      wlane_q         <= next_wlane;
      o_s_axi_awready <= next_awready;
      o_s_axi_wready  <= next_wready;
      o_s_axi_bvalid  <= next_bvalid;
      o_s_axi_bresp   <= next_bresp;
      o_s_axi_arready <= next_arready;
      o_s_axi_rvalid  <= next_rvalid;
      o_s_axi_rdata   <= next_rdata;
      o_s_axi_rresp   <= next_rresp;
    end
  end

  // =====================================================
  // Serial control registers: next values
  always_comb begin
    // Reception counts only while allowed
    rx_take = i_p1_rx_done && o_p1_rx_enable;                        // [R06]
    ri_set  = rx_take && spc_rx_valid(p1_mode, s1[`SPC_B_MP],
                                      i_p1_rx_stop, i_p1_rx_ninth,
                                      i_p1_rx_addr_match);           // [R03] [R04] [R05] [R10]
    ti_set  = i_p1_tx_done;                                          // [R09]
    fe1_set = rx_take && (p1_mode != 2'h0) && !i_p1_rx_stop;         // [R17]
    next_pwr      = pwr;
    next_t3       = t3;
    next_s0       = s0;
    next_s0_fe    = s0_fe;
    next_irq_stat = irq_stat;
    next_irq_en   = irq_en;
    next_bit_sel  = bit_sel;
    s1_mask       = 8'h00;
    s1_data       = 8'h00;
    // Software writes with the low byte lane enabled, whole bytes or one port1 bit
    if (wr_go && wlane_q) begin
      if (awaddr_q == spc_addr(`SPC_IDX_PWR)) begin
        next_pwr = wdata_q[7:0];
      end else if (awaddr_q == spc_addr(`SPC_IDX_S1CTL)) begin
        s1_mask = 8'hFF;
        s1_data = wdata_q[7:0];
      end else if (awaddr_q == spc_addr(`SPC_IDX_T3CTL)) begin
        next_t3 = wdata_q[7:0];
      end else if (awaddr_q == spc_addr(`SPC_IDX_S0CTL)) begin
        // Bit 7 goes to mode or flag by the port0 select
        next_s0 = spc_merge(s0, wdata_q[7:0], 8'h7F);
        if (pwr[`SPC_B_FESEL]) begin
          next_s0_fe = wdata_q[7];                                   // [R14]
        end else begin
          next_s0[`SPC_B_MODE_HI] = wdata_q[7];                      // [R14]
        end
      end else if (awaddr_q == spc_addr(`SPC_IDX_IEN)) begin
        next_irq_en = wdata_q[2:0];
      end else if (awaddr_q == spc_addr(`SPC_IDX_ICLR)) begin
        next_irq_stat = irq_stat & ~wdata_q[2:0];
      end else if (awaddr_q == spc_addr(`SPC_IDX_BITOP)) begin
        // Select a bit, and write it when asked
        next_bit_sel = wdata_q[2:0];                                 // [R15]
        if (wdata_q[`SPC_B_BITWR]) begin
          s1_mask = 8'h01 << wdata_q[2:0];                           // [R15]
          s1_data = {8{wdata_q[`SPC_B_BITVAL]}};
        end
      end
    end
    s1_wr = (s1_mask != 8'h00);
    // Port1 low seven bits, bit 7 routed by the timer3 select
    next_s1 = spc_merge(s1, s1_data, {1'b0, s1_mask[6:0]});
    next_s1_fe = s1_fe;
    if (s1_mask[7] && t3[`SPC_B_FESEL]) begin
      next_s1_fe = s1_data[7];                                       // [R02] [R16]
    end else if (s1_mask[7]) begin
      next_s1[`SPC_B_MODE_HI] = s1_data[7];                          // [R01] [R16]
    end
    // Hardware sets win over a software clear in the same cycle
    next_s1_fe = next_s1_fe | fe1_set;                               // [R02] [R17]
    next_s0_fe = next_s0_fe | i_p0_rx_frame_error;
    next_s1[`SPC_B_TI] = next_s1[`SPC_B_TI] | ti_set;                // [R09] [R11]
    next_s1[`SPC_B_RI] = next_s1[`SPC_B_RI] | ri_set;                // [R10] [R11]
    // Ninth bit or stop bit is kept only for accepted frames
    if (ri_set && p1_mode == 2'h1) begin
      next_s1[`SPC_B_RB8] = i_p1_rx_stop;                            // [R08]
    end else if (ri_set && p1_mode[1]) begin
      next_s1[`SPC_B_RB8] = i_p1_rx_ninth;                           // [R08]
    end
    next_irq_stat = next_irq_stat | {fe1_set, ri_set, ti_set};
    // Outputs follow the new state in the same edge
    next_p1_mode = {next_s1[`SPC_B_MODE_HI], next_s1[`SPC_B_MODE_LO]};  // [R01]
    next_p1_rx_enable = next_s1[`SPC_B_REN] &&
                        (next_p1_mode != 2'h0 || !next_s1[`SPC_B_RI]);  // [R06]
    next_p1_tx_ninth = next_p1_mode[1] && next_s1[`SPC_B_TB8];          // [R07]
    next_p0_mode = {next_s0[`SPC_B_MODE_HI], next_s0[`SPC_B_MODE_LO]};
    next_p0_baud_double = next_pwr[`SPC_B_BAUD2] &&
                          (next_p0_mode == 2'h2 ||
                           (next_p0_mode[0] && i_p0_t1_baud_src));      // [R13]
    next_irq = |(next_irq_stat & next_irq_en);                          // [R12]
  end

  // Serial control registers: registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pwr              <= `SPC_RST_PWR;
      t3               <= `SPC_RST_T3;
      s0               <= `SPC_RST_S0;
      s1               <= `SPC_RST_S1;
      s0_fe            <= 1'b0;
      s1_fe            <= 1'b0;
      irq_stat         <= `SPC_RST_IRQ;
      irq_en           <= `SPC_RST_IRQ;
      bit_sel          <= 3'h0;
      o_p1_mode        <= 2'h0;
      o_p1_rx_enable   <= 1'b0;
      o_p1_tx_ninth    <= 1'b0;
      o_p0_mode        <= 2'h0;
      o_p0_baud_double <= 1'b0;
      o_irq            <= 1'b0;
    end else begin
      pwr              <= next_pwr;
      t3               <= next_t3;
      s0               <= next_s0;
      s1               <= next_s1;
      s0_fe            <= next_s0_fe;
      s1_fe            <= next_s1_fe;
      irq_stat         <= next_irq_stat;
      irq_en           <= next_irq_en;
      bit_sel          <= next_bit_sel;
      o_p1_mode        <= next_p1_mode;
      o_p1_rx_enable   <= next_p1_rx_enable;
      o_p1_tx_ninth    <= next_p1_tx_ninth;
      o_p0_mode        <= next_p0_mode;
      o_p0_baud_double <= next_p0_baud_double;
      o_irq            <= next_irq;
    end
  end

  // =====================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Mode output tracks the stored mode bits
  property p_mode_out;
    (s1_wr && s1_mask[7] && !t3[`SPC_B_FESEL]) |=> (o_p1_mode[1] == $past(s1_data[7]));
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("mode bit not written"); // [R01]

  // Bad stop bit raises the frame error flag
  property p_fe_set;
    (rx_take && p1_mode != 2'h0 && !i_p1_rx_stop) |=> s1_fe;
  endproperty
  a_fe_set: assert property (p_fe_set) else $error("frame error lost"); // [R17]

  // Mode 0 reception sets the flag whatever the multiprocessor enable
  property p_mode0_rx;
    (p1_mode == 2'h0 && rx_take) |=> s1[`SPC_B_RI];
  endproperty
  a_mode0_rx: assert property (p_mode0_rx) else $error("mode 0 reception dropped"); // [R03]

  // Mode 1 with checking rejects a zero stop bit
  property p_mode1_reject;
    (p1_mode == 2'h1 && s1[`SPC_B_MP] && rx_take && !i_p1_rx_stop
     && !s1[`SPC_B_RI] && !s1_wr) |=> !s1[`SPC_B_RI];
  endproperty
  a_mode1_reject: assert property (p_mode1_reject) else $error("bad frame accepted"); // [R04]

  // Modes 2/3 accept a matching frame and keep its ninth bit
  property p_mode23_accept;
    (p1_mode[1] && s1[`SPC_B_MP] && rx_take && i_p1_rx_ninth && i_p1_rx_addr_match)
      |=> (s1[`SPC_B_RI] && s1[`SPC_B_RB8]);
  endproperty
  a_mode23_accept: assert property (p_mode23_accept) else $error("address frame lost"); // [R05]

  // Receive enable cleared blocks reception
  property p_ren_off;
    !s1[`SPC_B_REN] |-> !o_p1_rx_enable;
  endproperty
  a_ren_off: assert property (p_ren_off) else $error("reception not blocked"); // [R06]

  // Ninth transmit bit is quiet in modes 0 and 1
  property p_tb8_quiet;
    !o_p1_mode[1] |-> !o_p1_tx_ninth;
  endproperty
  a_tb8_quiet: assert property (p_tb8_quiet) else $error("ninth bit in low mode"); // [R07]

  // Finished transmission sets the flag on the next cycle
  property p_ti_set;
    i_p1_tx_done |=> s1[`SPC_B_TI];
  endproperty
  a_ti_set: assert property (p_ti_set) else $error("transmit flag not set"); // [R09]

  // Transmit flag falls only after a software write
  property p_no_hw_clear;
    (s1[`SPC_B_TI] && !s1_wr) |=> s1[`SPC_B_TI];
  endproperty
  a_no_hw_clear: assert property (p_no_hw_clear) else $error("flag cleared by hardware"); // [R11]

  // Enabled event reaches the interrupt output
  property p_irq;
    (ti_set && irq_en[0]) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised"); // [R12]

  // Covers for main scenarios
  c_rx_accept: cover property (ri_set ##1 o_irq);
  c_fe_select: cover property (t3[`SPC_B_FESEL] && s1_fe);
  c_bit_write: cover property (wr_go && s1_wr && s1_mask != 8'hFF);
  c_write_read: cover property (o_s_axi_bvalid ##[1:8] o_s_axi_rvalid);

endmodule
`default_nettype wire

// >>> sim/spc_line_model.sv
// Line-side partner: turns bench commands into port-1 frame-end events.
// Assumes one clock shared with the control block; commands last one cycle.
`default_nettype none
module spc_line_model (
  input  wire logic       i_clk,
  input  wire logic       i_rx_go,
  input  wire logic       i_tx_go,
  input  wire logic [2:0] i_bits,
  output var  logic       o_tx_done = 1'b0,
  output var  logic       o_rx_done = 1'b0,
  output var  logic [2:0] o_bits    = 3'h0
);
  // ==============================================
  // Event pulses and frame fields
  // Fields hold only with the receive pulse; otherwise they flip every cycle
  always @(posedge i_clk) begin
    o_rx_done <= i_rx_go;
    o_tx_done <= i_tx_go;
    o_bits    <= i_rx_go ? i_bits : ~o_bits;
  end
endmodule
`default_nettype wire

// >>> sim/test_serial_port_control.sv
// Bench top: register bus, receive gating, flags and interrupt of the port.
// Assumes the line model feeds the port-1 event inputs.
`default_nettype none
module test_serial_port_control;
  timeunit 1ns;
  timeprecision 1ps;
  import spc_pkg::*;
  // ==============================================
  // Signals
  logic        i_clk = 1'b0, i_rst = 1'b1, rx_go = 1'b0, tx_go = 1'b0, t1src = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        pfe = 1'b0, awready, wready, bvalid, arready, rvalid, txd, rxd;
  logic        rx_en, tx_ninth, baud2, irq;
  spc_addr_t   awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, got;
  logic [2:0]  bits = '0, fld;
  spc_resp_t   bresp, rresp, lastb, lastr;
  spc_mode_t   p1_mode, p0_mode;
  int          errors = 0, compares = 0;
  // Rows: control written, stop/ninth/match, control read back
  logic [19:0] rows [7] = '{20'h30031, 20'h70575, 20'h70170, 20'hB06B0,
                            20'hF07F5, 20'hD04D1, 20'h40440};
  localparam spc_addr_t A_S1 = 12'h3E0, A_T3 = 12'h310, A_PW = 12'h21C, A_S0 = 12'h260;
  localparam spc_addr_t A_ST = 12'h400, A_EN = 12'h404, A_CL = 12'h408, A_BAD = 12'h7FC;
  localparam spc_addr_t A_BIT = 12'h40C;
  always #12.5 i_clk = ~i_clk;
  // ==============================================
  // Instances
  spc_serial_port_control u_spc_serial_port_control (.i_clk(i_clk), .i_rst(i_rst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_p1_tx_done(txd),
    .i_p1_rx_done(rxd), .i_p1_rx_stop(fld[2]), .i_p1_rx_ninth(fld[1]),
    .i_p1_rx_addr_match(fld[0]), .i_p0_rx_frame_error(pfe), .i_p0_t1_baud_src(t1src),
    .o_p1_mode(p1_mode), .o_p1_rx_enable(rx_en), .o_p1_tx_ninth(tx_ninth),
    .o_p0_mode(p0_mode), .o_p0_baud_double(baud2), .o_irq(irq));
  spc_line_model u_spc_line_model (.i_clk(i_clk), .i_rx_go(rx_go), .i_tx_go(tx_go),
    .i_bits(bits), .o_tx_done(txd), .o_rx_done(rxd), .o_bits(fld));
  // ==============================================
  // Tasks
  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus write: address and data together, each dropped when taken
  task automatic wr(input spc_addr_t a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    awaddr <= a;
    wdata  <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge i_clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    lastb = bresp;
    bready <= 1'b0;
    if (n >= 50) begin
      errors++;
      give_verdict();
    end
  endtask
  // Bus read: result lands in got
  task automatic rd(input spc_addr_t a);
    int n;
    n = 0;
    @(posedge i_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge i_clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    got   = rdata;
    lastr = rresp;
    rready <= 1'b0;
    if (n >= 50) begin
      errors++;
      give_verdict();
    end
  endtask
  // One frame end from the line, then time for the flag to land
  task automatic ev(input logic rx, input logic [2:0] b);
    @(posedge i_clk);
    {rx_go, tx_go} <= {rx, ~rx};
    bits <= b;
    @(posedge i_clk);
    {rx_go, tx_go} <= 2'h0;
    repeat (2) @(posedge i_clk);
  endtask
  // ==============================================
  // Main sequence
  initial begin
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(A_PW);
    chk("power reset", 32'h10, got);
    rd(A_S1);
    chk("port1 reset", 32'h00, got);
    for (int i = 0; i < 7; i++) begin
      wr(A_S1, {24'h0, rows[i][19:12]});
      chk("p1 mode", {30'h0, rows[i][19:18]}, {30'h0, p1_mode});
      chk("rx enable", {31'h0, rows[i][16]}, {31'h0, rx_en});
      ev(1'b1, rows[i][10:8]);
      rd(A_S1);
      chk("rx frame", {24'h0, rows[i][7:0]}, got);
    end
    rd(A_ST);
    chk("status", 32'h6, got);
    wr(A_T3, 32'h40);
    rd(A_S1);
    chk("fe view", 32'hC0, got);
    wr(A_S1, 32'h40);
    rd(A_S1);
    chk("fe cleared", 32'h40, got);
    chk("mode kept", 32'h1, {30'h0, p1_mode});
    wr(A_T3, 32'h00);
    wr(A_CL, 32'h7);
    wr(A_EN, 32'h1);
    wr(A_S1, 32'h88);
    chk("tx ninth", 32'h1, {31'h0, tx_ninth});
    ev(1'b0, 3'h0);
    chk("irq on", 32'h1, {31'h0, irq});
    rd(A_S1);
    chk("tx flag", 32'h8A, got);
    wr(A_EN, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(A_EN, 32'h1);
    wr(A_CL, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(A_BIT, 32'h103);
    rd(A_S1);
    chk("bit write", 32'h82, got);
    wr(A_BIT, 32'h07);
    rd(A_BIT);
    chk("bit read", 32'h17, got);
    wr(A_BAD, 32'hFF);
    chk("bad bresp", 32'h2, {30'h0, lastb});
    rd(A_BAD);
    chk("bad rdata", 32'h0, got);
    chk("bad rresp", 32'h2, {30'h0, lastr});
    wr(A_PW, 32'h90);
    wr(A_S0, 32'h80);
    chk("double m2", 32'h1, {31'h0, baud2});
    wr(A_S0, 32'h40);
    chk("double m1", 32'h0, {31'h0, baud2});
    t1src <= 1'b1;
    repeat (2) @(posedge i_clk);
    chk("double t1", 32'h1, {31'h0, baud2});
    wr(A_PW, 32'hD0);
    pfe <= 1'b1;
    @(posedge i_clk);
    pfe <= 1'b0;
    rd(A_S0);
    chk("p0 fe view", 32'hC0, got);
    chk("p0 mode", 32'h1, {30'h0, p0_mode});
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(A_PW);
    chk("power rereset", 32'h10, got);
    give_verdict();
  end
endmodule
`default_nettype wire
